/* File: logic/qwpd_decode.sv */
/*
 * queued write parameter decoder: latches a queued write command, decodes
 * priority, deadline, commit rule and start address, tracks block writes,
 * reports completion and the first unrecoverable error address.
 * assumes every input is produced by logic on core_clk; strobes are one
 * cycle wide and a new command is offered only while busy is low.
 */
// Overview of operation
// - the deadline code only takes effect when the priority class is isochronous.
// - by default an expired command keeps running to completion as fast as possible.
// - when the host selects abort-on-expiry the device aborts expired commands.
// - with deadline bit 7 clear the limit is (low seven bits plus one) times 10 ms.
// - with deadline bit 7 set the limit is (low seven bits plus one) times 0.5 s.
// - with force-media-commit set completion waits until data are on the media.
// - with force-media-commit clear and caching on, completion may precede media.
// - error address bits 7:0 or 31:24 show in sector number per high-order select.
// - error address bits 15:8 or 39:32 show in cylinder low per high-order select.
// - error address bits 23:16 or 47:40 show in cylinder high per high-order select.
// - priority class one is isochronous, zero normal and two high.
// - after an unrecoverable error no further blocks of the command are written.
`timescale 1ns/1ns
`default_nettype none

module qwpd_decode
  import qwpd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = FINE_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire qwpd_cmd_s cmdFields,
  input wire logic writeCacheEnable,
  input wire logic abortOnExpiry,
  input wire logic hostDataDone,
  input wire logic mediaBlockOk,
  input wire logic mediaUncError,
  input wire logic mediaDone,
  input wire logic highOrderSelect,
  output logic busy,
  output qwpd_class_e priorityMode,
  output logic deadlineValid,
  output logic deadlineExpired,
  output logic [47:0] startLba,
  output logic [47:0] blockLba,
  output logic writeActive,
  output logic compDone,
  output qwpd_status_s compStatus,
  output logic [7:0] errSector,
  output logic [7:0] errCylLow,
  output logic [7:0] errCylHigh
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_DRAIN
  } qwpd_state_e;

  qwpd_state_e state;
  qwpd_state_e next_state;
  qwpd_cmd_s cmdReg;
  logic accept;
  logic forceCommit;
  logic cachedDone;
  logic abortNow;
  logic timerExpired;
  logic [47:0] errLba;
  logic errValid;
  qwpd_class_e next_class;

  assign accept = cmdValid && state == ST_IDLE;
  assign forceCommit = cmdReg.deviceHead[FORCE_COMMIT_BIT];
  // cached completion is allowed only without force-commit and with caching
  assign cachedDone = hostDataDone && !forceCommit && writeCacheEnable;
  assign abortNow = deadlineExpired && abortOnExpiry;

  always_comb begin
    case (cmdFields.priorityClass)
      CLASS_CODE_NORMAL: next_class = CLASS_NORMAL;
      CLASS_CODE_ISO: next_class = CLASS_ISO;
      CLASS_CODE_HIGH: next_class = CLASS_HIGH;
      default: next_class = CLASS_RSVD;
    endcase
  end

  qwpd_deadline_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) deadlineTimer (
    .core_clk(core_clk),
    .rst(rst),
    .start(accept && next_class == CLASS_ISO),
    .cancel(state == ST_IDLE && !accept),
    .deadlineCode(cmdFields.completionDeadlineCode),
    .expired(timerExpired)
  );

  // expiry only reported for isochronous work still in flight
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deadlineExpired <= 1'b0;
    end else begin
      deadlineExpired <= timerExpired && deadlineValid && state != ST_IDLE;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (mediaUncError || mediaDone || abortNow) begin
          next_state = ST_IDLE;
        end else if (cachedDone) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // already reported; an expiry here no longer aborts anything
        if (mediaUncError || mediaDone) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state != ST_IDLE;
    end
  end

  // command capture and decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdReg <= '0;
      priorityMode <= CLASS_NORMAL;
      deadlineValid <= 1'b0;
      startLba <= LBA_RESET;
    end else if (accept) begin
      cmdReg <= cmdFields;
      priorityMode <= next_class;
      deadlineValid <= next_class == CLASS_ISO;
      startLba <= {cmdFields.cylHighPrev, cmdFields.cylLowPrev,
                   cmdFields.sectorNumPrev, cmdFields.cylHighCur,
                   cmdFields.cylLowCur, cmdFields.sectorNumCur};
    end
  end

  // block address walk; writing stops at the failing block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blockLba <= LBA_RESET;
      writeActive <= 1'b0;
    end else if (accept) begin
      blockLba <= {cmdFields.cylHighPrev, cmdFields.cylLowPrev,
                   cmdFields.sectorNumPrev, cmdFields.cylHighCur,
                   cmdFields.cylLowCur, cmdFields.sectorNumCur};
      writeActive <= 1'b1;
    end else if (state != ST_IDLE && mediaUncError) begin
      writeActive <= 1'b0;
    end else if (state == ST_ACTIVE && abortNow) begin
      writeActive <= 1'b0;
    end else if (state != ST_IDLE && mediaDone) begin
      writeActive <= 1'b0;
    end else if (writeActive && mediaBlockOk) begin
      // expiry without abort selected does not stop the walk
      blockLba <= blockLba + 48'h1;
    end
  end

  // completion report
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compDone <= 1'b0;
      compStatus <= '0;
    end else begin
      compDone <= 1'b0;
      if (state == ST_ACTIVE) begin
        if (mediaUncError) begin
          compDone <= 1'b1;
          compStatus <= '{error: 1'b1, aborted: 1'b0, cached: 1'b0};
        end else if (mediaDone) begin
          compDone <= 1'b1;
          compStatus <= '{error: 1'b0, aborted: 1'b0, cached: 1'b0};
        end else if (abortNow) begin
          compDone <= 1'b1;
          compStatus <= '{error: 1'b0, aborted: 1'b1, cached: 1'b0};
        end else if (cachedDone) begin
          compDone <= 1'b1;
          compStatus <= '{error: 1'b0, aborted: 1'b0, cached: 1'b1};
        end
      end
    end
  end

  // first unrecoverable error address is kept until the next command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      errLba <= LBA_RESET;
      errValid <= 1'b0;
    end else if (accept) begin
      errValid <= 1'b0;
    end else if (state != ST_IDLE && mediaUncError && !errValid) begin
      errLba <= blockLba;
      errValid <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      errSector <= BYTE_RESET;
      errCylLow <= BYTE_RESET;
      errCylHigh <= BYTE_RESET;
    end else begin
      errSector <= highOrderSelect ? errLba[31:24] : errLba[7:0];
      errCylLow <= highOrderSelect ? errLba[39:32] : errLba[15:8];
      errCylHigh <= highOrderSelect ? errLba[47:40] : errLba[23:16];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_deadline_ignored: assert property (
    priorityMode != CLASS_ISO |-> !deadlineExpired)
    else $error("expiry flagged for non-isochronous command");

  chk_keep_running: assert property (
    compDone && compStatus.aborted |-> $past(abortOnExpiry) &&
      $past(deadlineExpired))
    else $error("command dropped without abort selected");

  chk_abort_expired: assert property (
    state == ST_ACTIVE && deadlineExpired && abortOnExpiry &&
      !mediaUncError && !mediaDone |=>
      compDone && compStatus.aborted && !writeActive)
    else $error("expired command not aborted");

  chk_commit_wait: assert property (
    compDone && !compStatus.error && !compStatus.aborted && forceCommit |->
      $past(mediaDone) && !compStatus.cached)
    else $error("forced commit reported before media");

  chk_cached_early: assert property (
    state == ST_ACTIVE && hostDataDone && writeCacheEnable && !forceCommit &&
      !mediaUncError && !mediaDone && !abortNow |=>
      compDone && compStatus.cached && busy)
    else $error("cached completion missing");

  // both select levels are checked, whichever one the host happens to use
  chk_err_sector: assert property (
    state != ST_IDLE && mediaUncError && !errValid |=> ##1
      errSector == ($past(highOrderSelect) ? $past(blockLba[31:24], 2) :
      $past(blockLba[7:0], 2)))
    else $error("sector number error byte wrong");

  chk_err_cyl_low: assert property (
    state != ST_IDLE && mediaUncError && !errValid |=> ##1
      errCylLow == ($past(highOrderSelect) ? $past(blockLba[39:32], 2) :
      $past(blockLba[15:8], 2)))
    else $error("cylinder low error byte wrong");

  chk_err_cyl_high: assert property (
    state != ST_IDLE && mediaUncError && !errValid |=> ##1
      errCylHigh == ($past(highOrderSelect) ? $past(blockLba[47:40], 2) :
      $past(blockLba[23:16], 2)))
    else $error("cylinder high error byte wrong");

  chk_class_decode: assert property (
    accept |=> priorityMode == ($past(cmdFields.priorityClass) == 2'h1 ?
      CLASS_ISO : $past(cmdFields.priorityClass) == 2'h2 ? CLASS_HIGH :
      $past(cmdFields.priorityClass) == 2'h0 ? CLASS_NORMAL : CLASS_RSVD))
    else $error("priority class decoded wrongly");

  chk_stop_on_error: assert property (
    state != ST_IDLE && mediaUncError && !accept |=>
      !writeActive && $stable(blockLba) ##1 !writeActive || busy)
    else $error("writing continued after error");

  chk_start_lba: assert property (
    accept |=> startLba[47:40] == $past(cmdFields.cylHighPrev) &&
      startLba[7:0] == $past(cmdFields.sectorNumCur) &&
      startLba[31:24] == $past(cmdFields.sectorNumPrev) && blockLba == startLba)
    else $error("start address assembled wrongly");

  chk_timer_fresh: assert property (
    accept |=> !deadlineExpired [*3])
    else $error("deadline expired immediately after accept");

  // the early report is the only one; the media finish stays silent
  chk_drain_quiet: assert property (
    state == ST_DRAIN && $past(state) == ST_DRAIN |-> !compDone)
    else $error("second completion during drain");

  chk_write_restart: assert property (
    $rose(writeActive) |-> $past(accept))
    else $error("writing resumed without a new command");

endmodule

`default_nettype wire

/* File: logic/qwpd_pkg.sv */
/*
 * shared constants and carriers for the queued write parameter decoder.
 * assumes a single 250 MHz core clock; all times are derived from it here.
 */
package qwpd_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 4;

  // deadline intervals; coarse must stay a whole multiple of fine
  localparam int unsigned FINE_INTERVAL_MS = 10;
  localparam int unsigned COARSE_INTERVAL_MS = 500;
  localparam int unsigned FINE_TICK_CYCLES =
    FINE_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [12:0] COARSE_RATIO =
    13'(COARSE_INTERVAL_MS / FINE_INTERVAL_MS);

  // deadline code fields
  localparam int unsigned DEADLINE_COARSE_BIT = 7;
  localparam int unsigned DEADLINE_LIMIT_MSB = 6;

  // device/head field
  localparam int unsigned FORCE_COMMIT_BIT = 7;

  // priority class codes
  localparam logic [1:0] CLASS_CODE_NORMAL = 2'h0;
  localparam logic [1:0] CLASS_CODE_ISO = 2'h1;
  localparam logic [1:0] CLASS_CODE_HIGH = 2'h2;

  // reset values
  localparam logic [47:0] LBA_RESET = 48'h0;
  localparam logic [7:0] BYTE_RESET = 8'h0;

  typedef enum logic [1:0] {
    CLASS_NORMAL,
    CLASS_ISO,
    CLASS_HIGH,
    CLASS_RSVD
  } qwpd_class_e;

  typedef struct packed {
    logic [1:0] priorityClass;
    logic [7:0] completionDeadlineCode;
    logic [7:0] deviceHead;
    logic [7:0] sectorNumCur;
    logic [7:0] sectorNumPrev;
    logic [7:0] cylLowCur;
    logic [7:0] cylLowPrev;
    logic [7:0] cylHighCur;
    logic [7:0] cylHighPrev;
  } qwpd_cmd_s;

  typedef struct packed {
    logic error;
    logic aborted;
    logic cached;
  } qwpd_status_s;

endpackage

/* File: logic/qwpd_deadline_timer.sv */
/*
 * deadline timer: counts 10 ms units up to the limit coded in a
 * completion deadline code and raises a sticky expiry flag.
 * assumes start is a single-cycle strobe on core_clk; cancel is a level held while the decoder is idle.
 */
`timescale 1ns/1ns
`default_nettype none

module qwpd_deadline_timer
  import qwpd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = FINE_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cancel,
  input wire logic [7:0] deadlineCode,
  output logic expired
);

  logic [31:0] tickCnt;
  logic [12:0] unitCnt;
  logic [12:0] limitUnits;
  logic running;
  logic [12:0] next_limit;
  logic tickEnd;

  // coarse units are whole multiples of the fine unit, so one tick serves
  always_comb begin
    next_limit = {6'h0, deadlineCode[DEADLINE_LIMIT_MSB:0]} + 13'h1;
    if (deadlineCode[DEADLINE_COARSE_BIT]) begin
      next_limit = 13'(next_limit * COARSE_RATIO);
    end
  end

  assign tickEnd = (tickCnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst || cancel) begin
      running <= 1'b0;
      tickCnt <= 32'h0;
      unitCnt <= 13'h0;
      limitUnits <= 13'h0;
    end else if (start) begin
      running <= 1'b1;
      tickCnt <= 32'h0;
      unitCnt <= 13'h0;
      limitUnits <= next_limit;
    end else if (running) begin
      tickCnt <= tickEnd ? 32'h0 : tickCnt + 32'h1;
      if (tickEnd) begin
        unitCnt <= unitCnt + 13'h1;
      end
      if (tickEnd && unitCnt + 13'h1 == limitUnits) begin
        running <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || cancel || start) begin
      expired <= 1'b0;
    end else if (running && tickEnd && unitCnt + 13'h1 == limitUnits) begin
      expired <= 1'b1;
    end
  end

  // elapsed cycles since start, only for checking
  logic [31:0] sinceStart;
  logic coarseSel;
  always_ff @(posedge core_clk) begin
    if (rst || start) begin
      sinceStart <= 32'h0;
    end else begin
      sinceStart <= sinceStart + 32'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      coarseSel <= 1'b0;
    end else if (start) begin
      coarseSel <= deadlineCode[DEADLINE_COARSE_BIT];
    end
  end

  chk_fine_limit: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(expired) && !coarseSel |->
      sinceStart == 32'(limitUnits) * 32'(TICK_CYCLES) && limitUnits <= 13'd128)
    else $error("fine deadline expired at wrong time");

  chk_coarse_limit: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(expired) && coarseSel |->
      sinceStart == 32'(limitUnits) * 32'(TICK_CYCLES) &&
      limitUnits % 13'd50 == 13'h0)
    else $error("coarse deadline expired at wrong time");

endmodule

`default_nettype wire

/* File: tb/qwpd_media_model.sv */
/*
 * media side model for the queued write decoder: writes blocks one after
 * another, then reports done, or an unrecoverable error at a chosen block.
 * assumes it is started by the bench after a command has been accepted;
 * its strobes change only at the falling edge of core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module qwpd_media_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic slow,
  input wire logic [7:0] blocks,
  input wire logic [7:0] failAt,
  output logic mediaBlockOk,
  output logic mediaUncError,
  output logic mediaDone
);
  logic [7:0] count;
  logic [1:0] gap;
  logic stopped;
  logic runQ;

  // run is taken on the rising edge so the falling-edge step never races
  // the bench, which also changes run on the falling edge
  always @(posedge core_clk) begin
    runQ <= run;
  end

  initial begin
    runQ = 1'b0;
    mediaBlockOk = 1'b0;
    mediaUncError = 1'b0;
    mediaDone = 1'b0;
    count = 8'h00;
    gap = 2'h0;
    stopped = 1'b0;
  end

  // strobes are single pulses, so there is no held level to release
  always @(negedge core_clk) begin
    mediaBlockOk = 1'b0;
    mediaUncError = 1'b0;
    mediaDone = 1'b0;
    if (!runQ) begin
      count = 8'h00;
      gap = 2'h0;
      stopped = 1'b0;
    end else if (!stopped && gap != 2'h0) begin
      gap = gap - 2'h1;
    end else if (!stopped) begin
      gap = slow ? 2'h2 : 2'h0;
      if (count == failAt) begin
        // the failing block ends the writing for good
        mediaUncError = 1'b1;
        stopped = 1'b1;
      end else if (count == blocks) begin
        mediaDone = 1'b1;
        stopped = 1'b1;
      end else begin
        mediaBlockOk = 1'b1;
        count = count + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
/*
 * self-checking bench for the queued write decoder with a media model.
 * assumes the decoder is built with a short deadline tick; every input
 * changes at the falling edge of core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
  import qwpd_pkg::*;
  localparam int unsigned TICKS = 4;
  logic core_clk, rst, cmdValid, writeCacheEnable, abortOnExpiry;
  logic hostDataDone, highOrderSelect, run, slow;
  logic mediaBlockOk, mediaUncError, mediaDone;
  logic busy, deadlineValid, deadlineExpired, writeActive, compDone;
  logic [7:0] blocks, failAt, errSector, errCylLow, errCylHigh;
  logic [47:0] startLba, blockLba, errLba;
  qwpd_cmd_s cmdFields;
  qwpd_class_e priorityMode;
  qwpd_status_s compStatus;
  qwpd_class_e classTab [4] = '{CLASS_NORMAL, CLASS_ISO, CLASS_HIGH,
    CLASS_RSVD};
  logic [7:0] dCode [4] = '{8'h02, 8'h02, 8'h80, 8'h02};
  logic dAbort [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int dCycles [4] = '{13, 13, 201, 0};
  int failCount, comparisons, pulses;

  qwpd_decode #(.TICK_CYCLES(TICKS)) uut (.core_clk(core_clk), .rst(rst),
    .cmdValid(cmdValid), .cmdFields(cmdFields),
    .writeCacheEnable(writeCacheEnable), .abortOnExpiry(abortOnExpiry),
    .hostDataDone(hostDataDone), .mediaBlockOk(mediaBlockOk),
    .mediaUncError(mediaUncError), .mediaDone(mediaDone),
    .highOrderSelect(highOrderSelect), .busy(busy),
    .priorityMode(priorityMode), .deadlineValid(deadlineValid),
    .deadlineExpired(deadlineExpired), .startLba(startLba),
    .blockLba(blockLba), .writeActive(writeActive), .compDone(compDone),
    .compStatus(compStatus), .errSector(errSector), .errCylLow(errCylLow),
    .errCylHigh(errCylHigh));

  qwpd_media_model media (.core_clk(core_clk), .run(run), .slow(slow),
    .blocks(blocks), .failAt(failAt), .mediaBlockOk(mediaBlockOk),
    .mediaUncError(mediaUncError), .mediaDone(mediaDone));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic testDone();
    $display("comparisons=%0d mismatches=%0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic issue(input logic [1:0] pc, input logic [7:0] dl,
                       input logic [7:0] dh);
    cmdFields.priorityClass = pc;
    cmdFields.completionDeadlineCode = dl;
    cmdFields.deviceHead = dh;
    cmdValid = 1'b1;
    tick(1);
    cmdValid = 1'b0;
  endtask

  // bounded wait for the completion pulse; a hang closes the run
  task automatic waitDone();
    int n;
    n = 0;
    while (compDone !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    if (compDone !== 1'b1) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      testDone();
    end
  endtask

  task automatic finishCmd(input logic [2:0] status);
    run = 1'b1;
    waitDone();
    check(compStatus, status);
    tick(1);
    run = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    {cmdValid, writeCacheEnable, abortOnExpiry, hostDataDone} = 4'h0;
    {highOrderSelect, run, slow} = 3'h0;
    blocks = 8'h02;
    failAt = 8'hff;
    cmdFields = '{2'h0, 8'h00, 8'h00, 8'hfe, 8'h44, 8'h22, 8'h55,
                  8'h33, 8'h66};
    failCount = 0;
    comparisons = 0;
    tick(4);
    rst = 1'b0;
    check({busy, compDone, writeActive, deadlineValid}, 4'h0);
    check(priorityMode, CLASS_NORMAL);
    check(startLba, 48'h0);
    $display("test reset done");

    for (int pc = 0; pc < 4; pc++) begin
      issue(pc[1:0], 8'h05, 8'h00);
      check(priorityMode, classTab[pc]);
      check(deadlineValid, pc == 1);
      check(startLba, 48'h6655443322fe);
      check({busy, writeActive}, 2'h3);
      issue(pc[1:0] ^ 2'h1, 8'h05, 8'h00);
      check(priorityMode, classTab[pc]);
      slow = pc[0];
      finishCmd(3'h0);
    end
    $display("test priority done");

    failAt = 8'h03;
    blocks = 8'h08;
    issue(2'h0, 8'h00, 8'h00);
    finishCmd(3'h4);
    check({busy, writeActive}, 2'h0);
    errLba = 48'h6655443322fe + 48'h3;
    check(blockLba, errLba);
    for (int h = 0; h < 2; h++) begin
      highOrderSelect = h[0];
      tick(2);
      check(errSector, h ? errLba[31:24] : errLba[7:0]);
      check(errCylLow, h ? errLba[39:32] : errLba[15:8]);
      check(errCylHigh, h ? errLba[47:40] : errLba[23:16]);
    end
    failAt = 8'hff;
    $display("test error address done");

    blocks = 8'h04;
    // third pass: no force-commit but caching off, so no early report
    for (int f = 0; f < 3; f++) begin
      writeCacheEnable = f != 2;
      issue(2'h0, 8'h00, {f[0], 7'h00});
      hostDataDone = 1'b1;
      tick(1);
      hostDataDone = 1'b0;
      check(compDone, f == 0);
      run = 1'b1;
      pulses = 0;
      for (int n = 0; n < 60; n++) begin
        tick(1);
        pulses += (compDone === 1'b1);
      end
      run = 1'b0;
      check(pulses, f != 0);
      check(busy, 1'b0);
      // drain after a cached report must not clear the cached mark
      check(compStatus, f ? 3'h0 : 3'h1);
    end
    writeCacheEnable = 1'b0;
    $display("test commit done");

    for (int d = 0; d < 4; d++) begin
      abortOnExpiry = dAbort[d];
      issue(d == 3 ? 2'h0 : 2'h1, dCode[d], 8'h00);
      if (dCycles[d] == 0) begin
        tick(40);
        check(deadlineExpired, 1'b0);
        finishCmd(3'h0);
      end else begin
        tick(dCycles[d] - 1);
        check(deadlineExpired, 1'b0);
        tick(1);
        check(deadlineExpired, 1'b1);
        tick(1);
        check(compDone, dAbort[d]);
        if (dAbort[d]) begin
          check(compStatus, 3'h2);
          check(busy, 1'b0);
        end else begin
          check(busy, 1'b1);
          finishCmd(3'h0);
        end
      end
    end
    $display("test deadline done");
    testDone();
  end
endmodule

`default_nettype wire
